// File: core/touch_scan_consts.vh
// Register offsets, field positions and reset values of the touch scan block
`ifndef TOUCH_SCAN_CONSTS_VH
`define TOUCH_SCAN_CONSTS_VH
`define GEN_CTRL_OFFSET 8'h00
`define SCAN_DATA_OFFSET 8'h04
`define WAKE_WAKE_HIGH_LIMIT_OFFSET 8'h08
`define CH_SEL_MSB 31
`define CH_SEL_LSB 28
`define DMA_SEL_BIT 23
`define SOFT_START_BIT 22
`define COUNT_MSB 15
`define HIGH_LIM_MSB 31
`define HIGH_LIM_LSB 16
`define LOW_LIM_MSB 15
`define SCAN_REPEAT_COUNT_MSB 12
`define SCAN_REPEAT_COUNT_LSB 8
`define EN_BIT 7
`define IRQ_EN_BIT 6
`define TRIG_SRC_BIT 4
`define BUSY_BIT 3
`define DONE_BIT 2
`define RANGE_SEL_BIT 1
`define OOR_FLAG_BIT 0
`define CH_SEL_RESET 4'h0
`define WAKE_HIGH_LIMIT_RESET 16'h0000
`define SCAN_REPEAT_COUNT_RESET 5'h00
`endif

// File: core/touch_scan_regs.v
// Touch scan control, data and wakeup threshold registers with scan sequencer
`timescale 1ns/1ps
`include "touch_scan_consts.vh"

module touch_scan_regs (
    input wire clk, // 100 MHz clock
    input wire rst_n, // Asynchronous reset, active low
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write enable
    input wire [7:0] wb_adr_i, // Wishbone byte address
    input wire [3:0] wb_sel_i, // Wishbone byte selects
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    output reg wb_ack_o, // Wishbone acknowledge
    input wire hw_trigger, // Hardware scan trigger, asynchronous
    input wire ref_tick, // Reference oscillator tick, asynchronous
    input wire sample_end, // Front end finished one sample, asynchronous
    output reg scan_start, // Pulse: front end starts one sample
    output reg [3:0] electrode_sel, // Channel under measurement
    output reg scan_irq, // Interrupt request level
    output reg dma_req, // DMA request level
    output reg scan_busy // Scan in progress
);

    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_NEXT = 3'b100;

    reg [3:0] channel_select_q;
    reg dma_request_select_q;
    reg [15:0] wake_high_limit_q;
    reg [15:0] wake_low_limit_q;
    reg [4:0] scan_repeat_count_q;
    reg enable_q;
    reg scan_irq_enable_q;
    reg trigger_source_select_q;
    reg out_of_range_event_select_q;
    reg scan_done_flag_q;
    reg out_of_range_q;
    reg [15:0] scan_count_result_q;
    reg [4:0] scans_done_q;
    reg [2:0] state_q;
    reg [2:0] hw_sync_q;
    reg [2:0] tick_sync_q;
    reg [2:0] end_sync_q;
    reg [31:0] read_word;

    // Rising edge seen between second and third synchroniser stage
    function rise;
        input [2:0] sync;
        begin
            rise = sync[1] && !sync[2];
        end
    endfunction

    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i;
    wire wr_ctrl = wr && (wb_adr_i == `GEN_CTRL_OFFSET);
    wire wr_data = wr && (wb_adr_i == `SCAN_DATA_OFFSET);
    wire wr_thr = wr && (wb_adr_i == `WAKE_WAKE_HIGH_LIMIT_OFFSET);
    wire hw_pulse = rise(hw_sync_q);
    wire tick_pulse = rise(tick_sync_q);
    wire end_pulse = rise(end_sync_q);
    wire soft_go = wr_data && wb_sel_i[2] && wb_dat_i[`SOFT_START_BIT]
        && !trigger_source_select_q;
    wire hard_go = hw_pulse && trigger_source_select_q;
    wire go = enable_q && (state_q == ST_IDLE) && (soft_go || hard_go);
    // A channel written together with the start bit is the one scanned
    wire [3:0] start_channel = (wr_data && wb_sel_i[3])
        ? wb_dat_i[`CH_SEL_MSB:`CH_SEL_LSB] : channel_select_q;
    wire clr_done = wr_ctrl && wb_sel_i[0] && wb_dat_i[`DONE_BIT];
    wire clr_range = wr_ctrl && wb_sel_i[0] && wb_dat_i[`OOR_FLAG_BIT];
    wire last_scan = (scans_done_q == scan_repeat_count_q);
    // Abort by disable never reports a finished scan
    wire finish = (state_q == ST_RUN) && end_pulse && last_scan && enable_q;
    wire outside = (scan_count_result_q > wake_high_limit_q)
        || (scan_count_result_q < wake_low_limit_q);
    wire range_event = out_of_range_event_select_q && finish && outside;
    wire event_pend = scan_irq_enable_q
        && (out_of_range_event_select_q ? out_of_range_q : scan_done_flag_q);

    // Byte-lane merge of one register byte
    function [7:0] merge;
        input sel;
        input [7:0] old;
        input [7:0] incoming;
        begin
            merge = sel ? incoming : old;
        end
    endfunction

    // Event goes to exactly one request line
    function route;
        input pend;
        input to_dma;
        input want_dma;
        begin
            route = pend && (to_dma == want_dma);
        end
    endfunction

    // Synchronisers: first stage feeds second only
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hw_sync_q <= 3'h0;
            tick_sync_q <= 3'h0;
            end_sync_q <= 3'h0;
        end
        else
        begin
            hw_sync_q <= {hw_sync_q[1:0], hw_trigger};
            tick_sync_q <= {tick_sync_q[1:0], ref_tick};
            end_sync_q <= {end_sync_q[1:0], sample_end};
        end
    end

    // Software registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_repeat_count_q <= `SCAN_REPEAT_COUNT_RESET;
            enable_q <= 1'b0;
            scan_irq_enable_q <= 1'b0;
            trigger_source_select_q <= 1'b0;
            out_of_range_event_select_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && wb_sel_i[1])
                scan_repeat_count_q <= wb_dat_i[`SCAN_REPEAT_COUNT_MSB:`SCAN_REPEAT_COUNT_LSB];
            if (wr_ctrl && wb_sel_i[0])
            begin
                enable_q <= wb_dat_i[`EN_BIT];
                scan_irq_enable_q <= wb_dat_i[`IRQ_EN_BIT];
                out_of_range_event_select_q <= wb_dat_i[`RANGE_SEL_BIT];
                if (state_q == ST_IDLE)
                    trigger_source_select_q <= wb_dat_i[`TRIG_SRC_BIT];
            end
        end
    end

    // Data register: channel and request select
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_select_q <= `CH_SEL_RESET;
            dma_request_select_q <= 1'b0;
        end
        else
        begin
            if (wr_data && wb_sel_i[3])
                channel_select_q <= wb_dat_i[`CH_SEL_MSB:`CH_SEL_LSB];
            if (wr_data && wb_sel_i[2])
                dma_request_select_q <= wb_dat_i[`DMA_SEL_BIT];
        end
    end

    // Wakeup thresholds, byte-lane writable
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_high_limit_q <= `WAKE_HIGH_LIMIT_RESET;
            wake_low_limit_q <= `WAKE_HIGH_LIMIT_RESET;
        end
        else
        begin
            if (wr_thr)
            begin
                wake_high_limit_q <= {merge(wb_sel_i[3], wake_high_limit_q[15:8],
                    wb_dat_i[31:24]), merge(wb_sel_i[2], wake_high_limit_q[7:0],
                    wb_dat_i[23:16])};
                wake_low_limit_q <= {merge(wb_sel_i[1], wake_low_limit_q[15:8],
                    wb_dat_i[15:8]), merge(wb_sel_i[0], wake_low_limit_q[7:0],
                    wb_dat_i[7:0])};
            end
        end
    end

    // Scan sequencer and result accumulation
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            scans_done_q <= 5'h00;
            scan_count_result_q <= 16'h0000;
            scan_start <= 1'b0;
            electrode_sel <= `CH_SEL_RESET;
            scan_busy <= 1'b0;
        end
        else
        begin
            scan_start <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        state_q <= ST_RUN;
                        scans_done_q <= 5'h00;
                        scan_count_result_q <= 16'h0000;
                        electrode_sel <= start_channel;
                        scan_start <= 1'b1;
                        scan_busy <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (tick_pulse)
                        scan_count_result_q <= scan_count_result_q + 16'h0001;
                    if (!enable_q)
                    begin
                        state_q <= ST_IDLE;
                        scan_busy <= 1'b0;
                    end
                    else if (end_pulse)
                    begin
                        if (last_scan)
                        begin
                            state_q <= ST_IDLE;
                            scan_busy <= 1'b0;
                        end
                        else
                            state_q <= ST_NEXT;
                    end
                end
                ST_NEXT:
                begin
                    scans_done_q <= scans_done_q + 5'h01;
                    scan_start <= 1'b1;
                    state_q <= ST_RUN;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    scan_busy <= 1'b0;
                end
            endcase
        end
    end

    // Event flags: set wins over write-one clear
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_done_flag_q <= 1'b0;
            out_of_range_q <= 1'b0;
        end
        else
        begin
            if (finish)
                scan_done_flag_q <= 1'b1;
            else if (clr_done)
                scan_done_flag_q <= 1'b0;
            if (range_event)
                out_of_range_q <= 1'b1;
            else if (clr_range)
                out_of_range_q <= 1'b0;
        end
    end

    // Event routing to interrupt or DMA request
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_irq <= 1'b0;
            dma_req <= 1'b0;
        end
        else
        begin
            scan_irq <= route(event_pend, dma_request_select_q, 1'b0);
            dma_req <= route(event_pend, dma_request_select_q, 1'b1);
        end
    end

    // Read decode, unmapped addresses read zero
    always @*
    begin
        read_word = 32'h0000_0000;
        case (wb_adr_i)
            `GEN_CTRL_OFFSET:
                read_word = {
                    19'h0_0000,
                    scan_repeat_count_q,
                    enable_q,
                    scan_irq_enable_q,
                    1'b0,
                    trigger_source_select_q,
                    scan_busy,
                    scan_done_flag_q,
                    out_of_range_event_select_q,
                    out_of_range_q
                };
            `SCAN_DATA_OFFSET:
                read_word = {
                    channel_select_q,
                    4'h0,
                    dma_request_select_q,
                    7'h00,
                    scan_count_result_q
                };
            `WAKE_WAKE_HIGH_LIMIT_OFFSET:
                read_word = {wake_high_limit_q, wake_low_limit_q};
            default:
                read_word = 32'h0000_0000;
        endcase
    end

    // Bus answer: one wait state, unmapped reads zero
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? read_word : 32'h0000_0000;
        end
    end

endmodule // touch_scan_regs

// File: tb/touch_scan_regs_props.sv
// Port-level checks of the touch scan register block
`timescale 1ns/1ps
module touch_scan_regs_props (
    input wire clk, // Clock
    input wire rst_n, // Reset
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    input wire wb_we_i, // Write
    input wire [7:0] wb_adr_i, // Address
    input wire [3:0] wb_sel_i, // Lanes
    input wire [31:0] wb_dat_i, // Write data
    input wire [31:0] wb_dat_o, // Read data
    input wire wb_ack_o, // Ack
    input wire hw_trigger, // Trigger
    input wire ref_tick, // Tick
    input wire sample_end, // Sample end
    input wire scan_start, // Start
    input wire [3:0] electrode_sel, // Channel
    input wire scan_irq, // Irq
    input wire dma_req, // DMA
    input wire scan_busy // Busy
);
    reg [7:0] mode_q;
    reg [3:0] ch_q;
    wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    wire go = wr && wb_adr_i == 8'h04 && wb_sel_i[2] && wb_dat_i[22] && mode_q[7] && !scan_busy;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            {mode_q, ch_q} <= 12'h000;
        else if (wr && wb_adr_i == 8'h00 && !scan_busy)
            mode_q <= wb_dat_i[7:0];
        else if (wr && wb_adr_i == 8'h04 && wb_sel_i[3])
            ch_q <= wb_dat_i[31:28];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_RSV_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |->
        {wb_dat_o[27:24], wb_dat_o[22:16]} == 11'h000) else $error("reserved bits set");
    AST_SW_START: assert property (go && !mode_q[4] |=> scan_start && scan_busy)
        else $error("soft start lost");
    AST_HW_HOLD: assert property (go && mode_q[4] |=> !scan_start)
        else $error("soft start in hw mode");
    AST_HW_START: assert property (mode_q[4] && mode_q[7] && !scan_busy && $rose(hw_trigger)
        |-> ##[2:5] scan_start) else $error("hw trigger lost");
    AST_CHAN: assert property (scan_start |-> electrode_sel == ch_q)
        else $error("wrong channel");
    AST_EXCL: assert property (!(scan_irq && dma_req)) else $error("irq and dma");
    AST_DONE_EVT: assert property ($fell(scan_busy) && mode_q[7:6] == 2'b11 && !mode_q[1]
        |-> ##[1:4] (scan_irq || dma_req)) else $error("no done event");
endmodule // touch_scan_regs_props
bind touch_scan_regs touch_scan_regs_props props (.*);

// File: tb/touch_front_model.sv
// Front end model: reference ticks, then end of each sample
`timescale 1ns/1ps
module touch_front_model (
    input wire clk, // Clock
    input wire scan_start, // Sample start
    input wire [3:0] pace, // Cycles per tick half
    output reg ref_tick, // Tick
    output reg sample_end // Sample end
);
    integer i;
    initial
    begin
        {ref_tick, sample_end} = 2'b00;
        forever
        begin
            @(posedge clk);
            if (scan_start)
            begin
                for (i = 0; i < 10; i = i + 1)
                begin
                    repeat (pace) @(posedge clk);
                    ref_tick <= !ref_tick;
                end
                repeat (3) @(posedge clk);
                sample_end <= 1'b1;
                repeat (2) @(posedge clk);
                sample_end <= 1'b0;
            end
        end
    end
endmodule // touch_front_model

// File: tb/test_touch_scan_regs.sv
// Self-checking bench of the touch scan register block
`timescale 1ns/1ps
module test_touch_scan_regs;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg cyc = 1'b0, we = 1'b0, hw_trigger = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0000_0000;
    reg [3:0] pace = 4'h2;
    wire [31:0] rdat;
    wire [3:0] el;
    wire ack, tick, s_end, start, irq, dma, busy;
    wire [2:0] st = {dma, irq, busy};
    reg [31:0] rd;
    reg [71:0] rows [0:3];
    integer miscompares = 0, checks_done = 0, k, n;
    always #5 clk = !clk;
    touch_scan_regs DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .hw_trigger(hw_trigger), .ref_tick(tick), .sample_end(s_end),
        .scan_start(start), .electrode_sel(el), .scan_irq(irq), .dma_req(dma), .scan_busy(busy));
    touch_front_model front (.clk(clk), .scan_start(start), .pace(pace), .ref_tick(tick),
        .sample_end(s_end));
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
    begin
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    end
    endtask
    task wt(input integer b);
    begin
        for (k = 0; st[b] !== 1'b1 && k < 2000; k = k + 1)
            @(posedge clk);
        chk({31'h0000_0000, st[b]}, 32'h0000_0001);
    end
    endtask
    task finish_test;
    begin
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    initial
    begin
        #300000;
        miscompares = miscompares + 1;
        finish_test;
    end
    initial
    begin
        rows[0] = {8'h08, 32'hABCD_1234, 32'hABCD_1234};
        rows[1] = {8'h04, 32'hFF3F_FFFF, 32'hF000_0000};
        rows[2] = {8'h04, 32'h7FC0_FFFF, 32'h7080_0000};
        rows[3] = {8'h0C, 32'hFFFF_FFFF, 32'h0000_0000};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (n = 0; n < 4; n = n + 1)
        begin
            wb(1'b1, rows[n][71:64], rows[n][63:32]);
            wb(1'b0, rows[n][71:64], 32'h0000_0000);
            chk(rd, rows[n][31:0]);
        end
        $display("register table done");
        wb(1'b1, 8'h00, 32'h0000_02C0);
        wb(1'b1, 8'h04, 32'h5040_0000);
        chk({28'h000_0000, el}, 32'h0000_0005);
        wt(1);
        wb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h5000_000F);
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_02C4);
        wb(1'b1, 8'h00, 32'h0000_02C4);
        repeat (3) @(posedge clk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        $display("soft scan done");
        pace <= 4'h6;
        wb(1'b1, 8'h04, 32'h50C0_0000);
        wt(2);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h5080_000F);
        wb(1'b1, 8'h00, 32'h0000_02C4);
        $display("dma scan done");
        wb(1'b1, 8'h00, 32'h0000_02D0);
        wb(1'b1, 8'h04, 32'h3040_0000);
        repeat (20) @(posedge clk);
        chk({31'h0000_0000, busy}, 32'h0000_0000);
        hw_trigger <= 1'b1;
        repeat (4) @(posedge clk);
        hw_trigger <= 1'b0;
        wt(0);
        chk({28'h000_0000, el}, 32'h0000_0003);
        wt(1);
        $display("hardware scan done");
        finish_test;
    end
endmodule // test_touch_scan_regs
